//--- verilog/asr_map.vh
// Constants for the serial readout block: frame lengths and timing counts.
// Assumes a 10 MHz system clock (100 ns period).
`ifndef ASR_MAP_VH
`define ASR_MAP_VH
`define ASR_FRAME_BITS 24
`define ASR_CFG_BITS 8
`define ASR_CLK_MHZ 10
`define ASR_TEST_DELAY_NS 12000
`define ASR_TEST_DELAY_CYC ((`ASR_TEST_DELAY_NS * `ASR_CLK_MHZ) / 1000)
`define ASR_EXT_TEST_NUM_X10 36
`define ASR_HALF_SCK_CYC 5
`define ASR_POR_NS 4000000
`define ASR_POR_CYC ((`ASR_POR_NS / 1000) * `ASR_CLK_MHZ)
`define ASR_CONV_CYC 2000
`endif

//--- verilog/asr_sync.v
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ns
`default_nettype none
module asr_sync (
	input wire clk_in,
	input wire srst_in,
	input wire d_in,
	input wire rst_val_in,
	output reg q_out
);
	reg meta_r;
	always @(posedge clk_in) begin
		if (srst_in) begin
			// Idle pin level as reset value avoids a false edge after reset
			meta_r <= rst_val_in;
			q_out <= rst_val_in;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- verilog/asr_buf2.v
// Two-entry valid/ready buffer carrying finished conversion results.
// Assumes both sides on clk_in.
`timescale 1ns/1ns
`default_nettype none
module asr_buf2 #(
	parameter WIDTH = 24
) (
	input wire clk_in,
	input wire srst_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_r [0:1];
	reg wp_r;
	reg rp_r;
	reg [1:0] cnt_r;
	wire push = in_valid_in && (cnt_r != 2'd2);
	wire pop = out_ready_in && (cnt_r != 2'd0);
	assign in_ready_out = (cnt_r != 2'd2);
	assign out_valid_out = (cnt_r != 2'd0);
	assign out_data_out = mem_r[rp_r];
	always @(posedge clk_in) begin
		if (srst_in) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'd0;
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data_in;
				wp_r <= ~wp_r;
			end
			if (pop)
				rp_r <= ~rp_r;
			if (push && !pop)
				cnt_r <= cnt_r + 2'd1;
			else if (pop && !push)
				cnt_r <= cnt_r - 2'd1;
		end
	end
endmodule
`default_nettype wire

//--- verilog/asr_readout.v
// Serial result readout of a delta-sigma converter: external 3-wire and
// internal-clock single-cycle modes. Pins are sampled through synchronisers.
// Notes on behaviour
// - Clock pin level at end of power-on reset picks external or internal mode.
// - External 3-wire with select low: data out shows active-low done flag.
// - Falling done flag loads the result into the output shift register.
// - Input sampled on rising clock edges, output changes on falling edges.
// - Twenty-fourth falling edge: data out high, new conversion begins.
// - Edges beyond the twenty-fourth are ignored; output stays one.
// - Internal mode chosen if clock pin high or floating at select fall.
// - Internal mode: select fall drives clock low and shows done flag.
// - Select rising before test delay returns to sleep, result kept.
// - Clock starts one status test delay after select fall or flag fall.
// - Internal mode: 24 generated rising edges, then clock high, new conversion.
// - Select rising mid-transfer aborts output and starts a new conversion.
// - Abort before last config bit discards input, keeps old configuration.
// - Pull-up off while clock pin low; on again when select rises after test.
// - Select rising while clock driven low leaves pin low; external mode next.
`timescale 1ns/1ns
`default_nettype none
`include "asr_map.vh"
module asr_readout #(
	parameter POR_CYC = `ASR_POR_CYC,
	parameter CONV_CYC = `ASR_CONV_CYC,
	parameter EXT_OSC = 0,
	parameter EXT_OSC_FREQUENCY_KHZ = 300
) (
	input wire clk_in,
	input wire srst_in,
	input wire cs_n_in,
	input wire sck_pin_in,
	input wire sdi_in,
	output reg sck_out,
	output reg sck_oe_out,
	output reg sck_pullup_out,
	output reg sdo_out,
	output reg sdo_oe_out,
	input wire [23:0] result_in,
	input wire result_valid_in,
	output reg result_ready_out,
	output reg [`ASR_CFG_BITS-1:0] cfg_out,
	output reg conv_start_out
);
	localparam FB = `ASR_FRAME_BITS;
	localparam integer TD_EXT = (`ASR_EXT_TEST_NUM_X10 * `ASR_CLK_MHZ * 100)
		/ EXT_OSC_FREQUENCY_KHZ;
	localparam integer TD_CYC = EXT_OSC ? ((TD_EXT < 1) ? 1 : TD_EXT) :
		`ASR_TEST_DELAY_CYC;
	localparam HALF = `ASR_HALF_SCK_CYC;
	localparam [3:0] S_CONV = 4'b0001;
	localparam [3:0] S_SLEEP = 4'b0010;
	localparam [3:0] S_TEST = 4'b0100;
	localparam [3:0] S_SHIFT = 4'b1000;

	wire cs_n_s;
	wire sck_s;
	wire sdi_s;
	asr_sync u_cs (.clk_in(clk_in), .srst_in(srst_in), .d_in(cs_n_in),
		.rst_val_in(1'b1), .q_out(cs_n_s));
	asr_sync u_sck (.clk_in(clk_in), .srst_in(srst_in), .d_in(sck_pin_in),
		.rst_val_in(1'b0), .q_out(sck_s));
	asr_sync u_sdi (.clk_in(clk_in), .srst_in(srst_in), .d_in(sdi_in),
		.rst_val_in(1'b0), .q_out(sdi_s));

	// Finished results wait here, two at most; result_ready_out lags the buffer by one cycle
	wire buf_valid;
	wire buf_in_ready;
	wire [23:0] buf_data;
	reg buf_pop;
	asr_buf2 #(.WIDTH(24)) u_buf (.clk_in(clk_in), .srst_in(srst_in),
		.in_valid_in(result_valid_in), .in_ready_out(buf_in_ready),
		.in_data_in(result_in), .out_valid_out(buf_valid),
		.out_ready_in(buf_pop), .out_data_out(buf_data));

	reg [3:0] st_r;
	reg por_done_r;
	reg [22:0] por_cnt_r;
	reg int_mode_r;
	reg cs_d_r;
	reg sck_d_r;
	reg [23:0] sh_r;
	reg [`ASR_CFG_BITS-1:0] cfg_sh_r;
	reg [5:0] bit_r;
	reg [15:0] tmr_r;
	reg [10:0] conv_r;
	reg tested_r;

	wire cs_fall = cs_d_r && !cs_n_s;
	wire cs_rise = !cs_d_r && cs_n_s;
	wire sck_rise = !sck_d_r && sck_s;
	wire sck_fall = sck_d_r && !sck_s;
	wire eoc_n = (st_r == S_CONV);

	always @(posedge clk_in) begin
		if (srst_in) begin
			st_r <= S_CONV;
			por_done_r <= 1'b0;
			por_cnt_r <= 23'd0;
			int_mode_r <= 1'b0;
			cs_d_r <= 1'b1;
			sck_d_r <= 1'b0;
			sh_r <= 24'h000000;
			cfg_sh_r <= {`ASR_CFG_BITS{1'b0}};
			cfg_out <= {`ASR_CFG_BITS{1'b0}};
			bit_r <= 6'd0;
			tmr_r <= 16'h0000;
			conv_r <= 11'd0;
			tested_r <= 1'b0;
			sck_out <= 1'b1;
			sck_oe_out <= 1'b0;
			sck_pullup_out <= 1'b1;
			sdo_out <= 1'b1;
			sdo_oe_out <= 1'b0;
			result_ready_out <= 1'b0;
			conv_start_out <= 1'b0;
			buf_pop <= 1'b0;
		end else begin
			cs_d_r <= cs_n_s;
			sck_d_r <= sck_s;
			conv_start_out <= 1'b0;
			buf_pop <= 1'b0;
			result_ready_out <= buf_in_ready;
			if (!por_done_r) begin
				if (por_cnt_r == POR_CYC[22:0] - 23'd1) begin
					por_done_r <= 1'b1;
					int_mode_r <= sck_s;
				end
				por_cnt_r <= por_cnt_r + 23'd1;
			end else begin
				if (cs_fall)
					int_mode_r <= sck_s;
				// Pull-up drops whenever the pin reads low; a floating pin stays low
				if (!sck_s)
					sck_pullup_out <= 1'b0;
				else if (cs_rise && tested_r)
					sck_pullup_out <= 1'b1;
				if (cs_rise)
					tested_r <= 1'b0;
				sdo_oe_out <= !cs_n_s;
				case (st_r)
				S_CONV: begin
					sdo_out <= 1'b1;
					if (cs_fall && sck_s) begin
						sck_out <= 1'b0;
						sck_oe_out <= 1'b1;
					end
					// Released low the pin stays low, as the pull-up is off
					if (cs_rise && sck_oe_out)
						sck_oe_out <= 1'b0;
					if (conv_r >= CONV_CYC[10:0] - 11'd1 && buf_valid) begin
						sh_r <= buf_data;
						buf_pop <= 1'b1;
						st_r <= S_SLEEP;
						bit_r <= 6'd0;
						tmr_r <= 16'h0000;
						conv_r <= 11'd0;
					end else if (conv_r < CONV_CYC[10:0] - 11'd1)
						conv_r <= conv_r + 11'd1;
				end
				S_SLEEP: begin
					sdo_out <= 1'b0;
					if (int_mode_r) begin
						if (cs_rise) begin
							sck_oe_out <= 1'b0;
							tmr_r <= 16'h0000;
						end else if (!cs_n_s) begin
							sck_out <= 1'b0;
							sck_oe_out <= 1'b1;
							tested_r <= 1'b1;
							st_r <= S_TEST;
							tmr_r <= 16'h0000;
						end
					end else if (!cs_n_s && sck_rise) begin
						cfg_sh_r <= {cfg_sh_r[`ASR_CFG_BITS-2:0], sdi_s};
						bit_r <= 6'd1;
						st_r <= S_SHIFT;
					end
				end
				S_TEST: begin
					if (cs_rise) begin
						st_r <= S_SLEEP;
						sck_oe_out <= 1'b0;
					end else if (tmr_r == TD_CYC[15:0] - 16'd1) begin
						sck_out <= 1'b1;
						cfg_sh_r <= {cfg_sh_r[`ASR_CFG_BITS-2:0], sdi_s};
						bit_r <= 6'd1;
						tmr_r <= 16'h0000;
						st_r <= S_SHIFT;
					end else
						tmr_r <= tmr_r + 16'd1;
				end
				S_SHIFT: begin
					if (cs_rise && int_mode_r) begin
						st_r <= S_CONV;
						conv_start_out <= 1'b1;
						conv_r <= 11'd0;
						sck_out <= 1'b1;
						sck_oe_out <= 1'b0;
					end else if (int_mode_r) begin
						if (tmr_r == HALF[15:0] - 16'd1) begin
							tmr_r <= 16'h0000;
							if (sck_out) begin
								// Clock stays driven high after the last rise
								if (bit_r == FB[5:0]) begin
									st_r <= S_CONV;
									sdo_out <= 1'b1;
									conv_start_out <= 1'b1;
									conv_r <= 11'd0;
								end else begin
									sck_out <= 1'b0;
									sdo_out <= sh_r[23];
									sh_r <= {sh_r[22:0], 1'b1};
								end
							end else begin
								sck_out <= 1'b1;
								bit_r <= bit_r + 6'd1;
								if (bit_r < `ASR_CFG_BITS)
									cfg_sh_r <= {cfg_sh_r[`ASR_CFG_BITS-2:0],
										sdi_s};
								if (bit_r == `ASR_CFG_BITS - 1)
									cfg_out <= {cfg_sh_r[`ASR_CFG_BITS-2:0],
										sdi_s};
							end
						end else
							tmr_r <= tmr_r + 16'd1;
					end else begin
						if (sck_fall) begin
							sdo_out <= sh_r[23];
							sh_r <= {sh_r[22:0], 1'b1};
							if (bit_r == FB[5:0]) begin
								st_r <= S_CONV;
								sdo_out <= 1'b1;
								conv_start_out <= 1'b1;
								conv_r <= 11'd0;
							end
						end
						if (sck_rise && bit_r < FB[5:0]) begin
							bit_r <= bit_r + 6'd1;
							if (bit_r < `ASR_CFG_BITS)
								cfg_sh_r <= {cfg_sh_r[`ASR_CFG_BITS-2:0],
									sdi_s};
							if (bit_r == `ASR_CFG_BITS - 1)
								cfg_out <= {cfg_sh_r[`ASR_CFG_BITS-2:0],
									sdi_s};
						end
						if (cs_rise) begin
							st_r <= S_CONV;
							conv_start_out <= 1'b1;
							conv_r <= 11'd0;
						end
					end
				end
				default: st_r <= S_CONV;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- test/asr_readout_props.sv
// Checker for asr_readout pin behaviour.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module asr_readout_props (
	input wire clk_in,
	input wire srst_in,
	input wire cs_n_in,
	input wire sck_pin_in,
	input wire sck_out,
	input wire sck_oe_out,
	input wire sck_pullup_out,
	input wire sdo_out,
	input wire sdo_oe_out,
	input wire [7:0] cfg_out,
	input wire conv_start_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	chk_sdo_hiz_high: assert property (cs_n_in[*6] |-> !sdo_oe_out)
		else $error("sdo driven while select high");
	chk_oe_cs_rise: assert property ($rose(cs_n_in) |-> ##[1:6] !sdo_oe_out)
		else $error("sdo not released after select rise");
	chk_start_pulse: assert property (conv_start_out |=> !conv_start_out)
		else $error("start pulse too long");
	chk_start_sdo_high: assert property (conv_start_out && !cs_n_in |-> ##[0:2] sdo_out)
		else $error("sdo low at new conversion");
	chk_sdo_held_high: assert property ((!sck_oe_out && sck_pin_in && !cs_n_in)[*5]
		|-> $stable(sdo_out))
		else $error("sdo moved while clock high");
	chk_cfg_hold_idle: assert property (cs_n_in[*8] |-> $stable(cfg_out))
		else $error("cfg moved while deselected");
	chk_pullup_low_off: assert property (sck_oe_out && !sck_out |-> ##[0:3] !sck_pullup_out)
		else $error("pull-up on while clock low");
	chk_half_low_len: assert property (sck_oe_out && $fell(sck_out) |-> (!sck_out)[*5])
		else $error("internal clock low phase short");
	cov_start: cover property (conv_start_out);
	cov_int_low: cover property (sck_oe_out && !sck_out);
	cov_cs_rise: cover property ($rose(cs_n_in));
endmodule
bind asr_readout asr_readout_props u_props (.clk_in(clk_in), .srst_in(srst_in),
	.cs_n_in(cs_n_in), .sck_pin_in(sck_pin_in), .sck_out(sck_out),
	.sck_oe_out(sck_oe_out), .sck_pullup_out(sck_pullup_out), .sdo_out(sdo_out),
	.sdo_oe_out(sdo_oe_out), .cfg_out(cfg_out), .conv_start_out(conv_start_out));
`default_nettype wire

//--- test/asr_host.sv
// Host controller model: drives select, clock and data in; reads data out.
// Assumes phases of ten system cycles, well above the minimum.
`timescale 1ns/1ns
`default_nettype none
module asr_host (
	input wire logic clk_in,
	input wire logic sdo_in,
	input wire logic sck_pin_in,
	output var logic cs_n_out,
	output var logic sck_out,
	output var logic sck_oe_out,
	output var logic sdi_out
);
	// Clock held low through reset so the external mode is picked
	initial begin
		cs_n_out = 0;
		sck_out = 0;
		sck_oe_out = 1;
		sdi_out = 0;
	end
	task automatic set_pins(input logic cs, input logic oe);
		@(negedge clk_in);
		cs_n_out = cs;
		sck_oe_out = oe;
		sck_out = 0;
	endtask
	// Called once the flag is low; bits past 24 are counted when one
	task automatic ext_frame(input logic [7:0] cfg, input int n,
		output logic [23:0] w, output int ones);
		int i;
		w = 24'h000000;
		ones = 0;
		for (i = 0; i < n; i++) begin
			@(negedge clk_in);
			sdi_out = (i < 8) ? cfg[7-i] : 1'b0;
			repeat (10) @(negedge clk_in);
			sck_out = 1;
			if (i < 24) w[23-i] = sdo_in;
			else if (sdo_in === 1'b1) ones++;
			repeat (10) @(negedge clk_in);
			sck_out = 0;
		end
		repeat (10) @(negedge clk_in);
	endtask
	task automatic int_frame(output logic [23:0] w, output int n);
		int i;
		n = 0;
		while (sck_pin_in !== 1'b1 && n < 1000) begin
			@(negedge clk_in);
			n++;
		end
		w[23] = sdo_in;
		for (i = 22; i >= 0; i--) begin
			@(posedge sck_pin_in);
			w[i] = sdo_in;
		end
	endtask
endmodule
`default_nettype wire

//--- test/tb_asr_readout.sv
// Self-checking bench for asr_readout with a host model.
// Assumes shortened power-on and conversion counts.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("BAD %0t mismatch", $time); end end
module tb_asr_readout;
	logic clk_in = 0, srst_in = 1, result_valid_in = 0, sdo_q = 0;
	logic [23:0] result_in = 24'h000000, w;
	int errors = 0, tests_run = 0, n;
	wire cs_n, h_sck, h_oe, sdi, sck_d, sck_oe, sck_pu, sdo, sdo_oe, rdy, cst;
	wire [7:0] cfg;
	// Undriven clock pin only rises through the enabled weak pull-up
	wire sck_pin = sck_oe ? sck_d : (h_oe ? h_sck : sck_pu);
	wire sdo_w = sdo_oe ? sdo : ~sdo_q;
	initial forever #50 clk_in = ~clk_in;
	always @(posedge clk_in) if (sdo_oe) sdo_q <= sdo;
	asr_readout #(.POR_CYC(20), .CONV_CYC(400)) u_dut (.clk_in(clk_in),
		.srst_in(srst_in), .cs_n_in(cs_n), .sck_pin_in(sck_pin), .sdi_in(sdi),
		.sck_out(sck_d), .sck_oe_out(sck_oe), .sck_pullup_out(sck_pu),
		.sdo_out(sdo), .sdo_oe_out(sdo_oe), .result_in(result_in),
		.result_valid_in(result_valid_in), .result_ready_out(rdy),
		.cfg_out(cfg), .conv_start_out(cst));
	asr_host u_host (.clk_in(clk_in), .sdo_in(sdo_w), .sck_pin_in(sck_pin),
		.cs_n_out(cs_n), .sck_out(h_sck), .sck_oe_out(h_oe), .sdi_out(sdi));
	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task push(input logic [23:0] v);
		int k;
		@(negedge clk_in);
		result_in = v;
		result_valid_in = 1;
		k = 0;
		do begin @(posedge clk_in); k++; end while (rdy !== 1'b1 && k < 100);
		@(negedge clk_in);
		result_valid_in = 0;
	endtask
	task wait_flag;
		int k;
		for (k = 0; k < 1000 && sdo_w !== 1'b0; k++) @(negedge clk_in);
	endtask
	task t_ext;
		int ones;
		push(24'h5a3c96);
		push(24'hc3e187);
		@(negedge clk_in);
		`CHK(rdy, 1'b0)
		wait_flag;
		`CHK(sdo_w, 1'b0)
		u_host.ext_frame(8'ha5, 32, w, ones);
		`CHK(w, 24'h5a3c96 >> 1)
		`CHK(ones, 8)
		`CHK(cfg, 8'ha5)
		`CHK(sdo_w, 1'b1)
		push(24'h0f0f0f);
		wait_flag;
		u_host.ext_frame(8'h3c, 24, w, ones);
		`CHK(w, 24'hc3e187 >> 1)
		$display("t_ext done");
	endtask
	task t_abort;
		int ones;
		wait_flag;
		u_host.ext_frame(8'h81, 4, w, ones);
		u_host.set_pins(1, 1);
		repeat (8) @(negedge clk_in);
		`CHK(sdo_oe, 1'b0)
		`CHK(cfg, 8'h3c)
		u_host.set_pins(0, 1);
		repeat (8) @(negedge clk_in);
		`CHK(sdo_w, 1'b1)
		$display("t_abort done");
	endtask
	task t_int;
		u_host.set_pins(1, 0);
		srst_in = 1;
		repeat (6) @(negedge clk_in);
		srst_in = 0;
		repeat (30) @(negedge clk_in);
		push(24'ha1b2c3);
		repeat (450) @(negedge clk_in);
		u_host.set_pins(0, 0);
		repeat (6) @(negedge clk_in);
		`CHK(sck_oe & ~sck_d, 1'b1)
		u_host.int_frame(w, n);
		`CHK(n + 6 >= 120 && n + 6 <= 127, 1'b1)
		`CHK(w, 24'ha1b2c3 >> 1)
		repeat (20) @(negedge clk_in);
		`CHK(sck_pin & sdo_w, 1'b1)
		$display("t_int done");
	endtask
	initial begin
		repeat (6) @(negedge clk_in);
		srst_in = 0;
		repeat (22) @(negedge clk_in);
		t_ext;
		t_abort;
		t_int;
		conclude;
	end
	initial begin
		#3000000;
		errors++;
		conclude;
	end
endmodule
`default_nettype wire
